// ===== verilog/rcsc_core.sv
// Real-time clock core: BCD time counters, status byte, control bits, link crossing.
`timescale 1ns/1ps
// Contract
// - Time held in BCD: hundredths 00-99, sec/min 00-59, date 1-31, month 1-12, year 0-99.
// - Hundredths register is read-only; writes leave it unchanged.
// - Weekday counts 0 to 6 then wraps to 0; default 0.
// - Hour select bit set gives 0-23; clear gives 1-12 with PM bit; default 12h.
// - Every year divisible by 4 gets February 29; no century exception.
// - Status byte at 3Fh: backup 7, alarms 6/5, reg latch 2, latch 1, loss 0.
// - Backup flag is read-only, 1 while on backup supply, 0 on main supply.
// - Alarm flag sets on its match regardless of interrupt enable.
// - Status read clears alarm flags set at read start; later-set flags stay.
// - Register write latch powers up clear; must be 1 before control writes.
// - With write latch clear, control and array writes are ignored, not acknowledged.
// - Status write 02h sets write latch; 00h clears it; otherwise it holds.
// - Control writes need write latch then register write latch set first.
// - Power-loss flag sets after both supplies were lost; one loss does not.
// - After total loss registers default, time halts until first clock write.
// - Status bits 3 and 4 read zero; host writes zeros there.
// - Array writes inside the range chosen by the protect field are ignored.
// - Watchdog field: 00 1.75 s, 01 750 ms, 10 250 ms, 11 off.
// - Each alarm drives the interrupt only when its own enable is set.
// - Repeat bit 0 gives single alarm events; 1 gives recurring events.
// - Alarm match gives one interrupt pulse of about 20 ms; recurs in repeat mode.
// - Output select: 00 interrupt, 01 32.768 kHz, 10 100 Hz, 11 1 Hz.
// - Slave nibble 1101 selects the clock/control space.
module rcsc_core import rcsc_pkg::*; #(
	parameter int PULSE_CYCLES = IRQ_PULSE_CYCLES
) (
	input wire logic sys_clk,
	input wire logic rst,
	input wire logic link_clk,
	input wire logic link_req,
	input wire rcsc_op_e link_op,
	input wire logic [3:0] link_space,
	input wire logic [15:0] link_addr,
	input wire logic [7:0] link_wdata,
	output logic link_busy,
	output logic link_done,
	output logic link_ack,
	output logic [7:0] link_rdata,
	input wire logic osc_in,
	input wire logic vcc_good,
	input wire logic vback_good,
	input wire logic [1:0] alarm_match,
	input wire logic wd_kick,
	output logic wd_expire,
	output logic irq_n,
	output logic frequency_out_pin,
	output logic array_wr,
	output logic [15:0] array_addr,
	output logic [7:0] array_wdata
);
	localparam int PW = $clog2(PULSE_CYCLES + 1);

	if (PULSE_CYCLES < 1) begin : g_bad_pulse
		$error("PULSE_CYCLES must be at least one");
	end

	// ****************************************
	// Link domain: request capture and answer.
	// ****************************************
	logic lrst_meta, lrst;
	logic req_tgl, done_meta, done_sync, done_prev;
	rcsc_op_e h_op;
	logic [3:0] h_space;
	logic [15:0] h_addr;
	logic [7:0] h_wdata;
	logic done_tgl, ans_ack;
	logic [7:0] ans_rdata;

	always_ff @(posedge link_clk) begin
		lrst_meta <= rst;
		lrst <= lrst_meta;
	end

	always_ff @(posedge link_clk) begin
		if (lrst) begin
			done_meta <= 1'b0;
			done_sync <= 1'b0;
			done_prev <= 1'b0;
		end else begin
			done_meta <= done_tgl;
			done_sync <= done_meta;
			done_prev <= done_sync;
		end
	end

	// Held fields stay stable until the answer returns, so the system side reads them directly.
	always_ff @(posedge link_clk) begin
		if (lrst) begin
			req_tgl <= 1'b0;
			link_busy <= 1'b0;
			h_op <= OP_STOP;
			h_space <= 4'h0;
			h_addr <= 16'h0000;
			h_wdata <= 8'h00;
		end else if (link_req && !link_busy) begin
			req_tgl <= ~req_tgl;
			link_busy <= 1'b1;
			h_op <= link_op;
			h_space <= link_space;
			h_addr <= link_addr;
			h_wdata <= link_wdata;
		end else if (done_sync ^ done_prev) begin
			link_busy <= 1'b0;
		end
	end

	always_ff @(posedge link_clk) begin
		if (lrst) begin
			link_done <= 1'b0;
			link_ack <= 1'b0;
			link_rdata <= 8'h00;
		end else begin
			link_done <= done_sync ^ done_prev;
			if (done_sync ^ done_prev) begin
				link_ack <= ans_ack;
				link_rdata <= ans_rdata;
			end
		end
	end

	// ****************************************
	// Pin synchronisers and power supervision.
	// ****************************************
	logic req_meta, req_sync, req_prev, new_req;
	logic osc_meta, osc_sync, osc_prev;
	logic vcc_meta, vcc_sync, vbk_meta, vbk_sync;
	logic total_loss, dflt;

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			req_meta <= 1'b0;
			req_sync <= 1'b0;
			req_prev <= 1'b0;
			osc_meta <= 1'b0;
			osc_sync <= 1'b0;
			osc_prev <= 1'b0;
			vcc_meta <= 1'b1;
			vcc_sync <= 1'b1;
			vbk_meta <= 1'b1;
			vbk_sync <= 1'b1;
		end else begin
			req_meta <= req_tgl;
			req_sync <= req_meta;
			req_prev <= req_sync;
			osc_meta <= osc_in;
			osc_sync <= osc_meta;
			osc_prev <= osc_sync;
			vcc_meta <= vcc_good;
			vcc_sync <= vcc_meta;
			vbk_meta <= vback_good;
			vbk_sync <= vbk_meta;
		end
	end

	assign new_req = req_sync ^ req_prev;
	assign total_loss = !vcc_sync && !vbk_sync;
	assign dflt = rst || total_loss;

	// ****************************************
	// Request decode.
	// ****************************************
	logic is_ccr, is_arr, is_clock_reg, is_ctrl_reg, is_status;
	logic wl, rwl, sr_written, ccr_wrote, loss_flag, backup_flag;
	logic [1:0] al_flag, al_snap;
	logic [7:0] hund, sec, min, hour, date, month, year;
	logic [2:0] wday;
	logic [7:0] prot_reg, irq_reg;
	logic wr_req, ccr_accept, protected_addr;
	logic [7:0] rd_mux, status_view;

	assign is_ccr = h_space == SPACE_CCR;
	assign is_arr = h_space == SPACE_ARRAY;
	assign is_status = is_ccr && h_addr == ADDR_STATUS;
	assign is_clock_reg = is_ccr && h_addr >= ADDR_SEC && h_addr <= ADDR_HUND;
	assign is_ctrl_reg = is_ccr && (h_addr == ADDR_PROTECT || h_addr == ADDR_IRQCTL);
	assign wr_req = new_req && h_op == OP_WRITE;
	assign ccr_accept = wr_req && (is_clock_reg || is_ctrl_reg) && wl && rwl;

	always_comb begin
		unique case (prot_reg[7:5])
			3'h1: protected_addr = h_addr >= PROT_QUARTER;
			3'h2: protected_addr = h_addr >= PROT_HALF;
			3'h3: protected_addr = 1'b1;
			3'h4: protected_addr = h_addr <= PROT_PG1;
			3'h5: protected_addr = h_addr <= PROT_PG2;
			3'h6: protected_addr = h_addr <= PROT_PG4;
			3'h7: protected_addr = h_addr <= PROT_PG8;
			default: protected_addr = 1'b0;
		endcase
	end

	always_comb begin
		status_view = 8'h00;
		status_view[ST_BACKUP] = backup_flag;
		status_view[ST_AL1] = al_flag[1];
		status_view[ST_AL0] = al_flag[0];
		status_view[ST_RWL] = rwl;
		status_view[ST_WL] = wl;
		status_view[ST_LOSS] = loss_flag;
		unique case (h_addr)
			ADDR_STATUS: rd_mux = status_view;
			ADDR_HUND: rd_mux = hund;
			ADDR_WDAY: rd_mux = {5'h00, wday};
			ADDR_YEAR: rd_mux = year;
			ADDR_MONTH: rd_mux = month;
			ADDR_DATE: rd_mux = date;
			ADDR_HOUR: rd_mux = hour;
			ADDR_MIN: rd_mux = min;
			ADDR_SEC: rd_mux = sec;
			ADDR_PROTECT: rd_mux = {prot_reg[7:3], 3'h0};
			ADDR_IRQCTL: rd_mux = {irq_reg[7:3], 3'h0};
			default: rd_mux = 8'h00;
		endcase
		if (!is_ccr) begin
			rd_mux = 8'h00;
		end
	end

	// Answer to the link; the toggle moves with the data so both land together.
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			done_tgl <= 1'b0;
			ans_ack <= 1'b0;
			ans_rdata <= 8'h00;
		end else if (new_req) begin
			done_tgl <= ~done_tgl;
			ans_rdata <= 8'h00;
			unique case (h_op)
				OP_WRITE: begin
					if (is_status) begin
						ans_ack <= !sr_written;
					end else begin
						ans_ack <= (is_ccr || is_arr) && wl;
					end
				end
				OP_READ_BEGIN: begin
					ans_ack <= is_ccr || is_arr;
					ans_rdata <= rd_mux;
				end
				OP_READ_END: ans_ack <= 1'b1;
				OP_STOP: ans_ack <= 1'b1;
			endcase
		end
	end

	// ****************************************
	// Write latches.
	// ****************************************
	always_ff @(posedge sys_clk) begin
		if (dflt) begin
			wl <= 1'b0;
			rwl <= 1'b0;
			sr_written <= 1'b0;
			ccr_wrote <= 1'b0;
		end else if (new_req && h_op == OP_STOP) begin
			sr_written <= 1'b0;
			if (ccr_wrote) begin
				rwl <= 1'b0;
				ccr_wrote <= 1'b0;
			end
		end else if (wr_req && is_status && !sr_written) begin
			sr_written <= 1'b1;
			if (h_wdata == SR_SET_WL) begin
				wl <= 1'b1;
			end else if (h_wdata == SR_SET_RWL && wl) begin
				rwl <= 1'b1;
			end else if (h_wdata == SR_CLEAR) begin
				wl <= 1'b0;
				rwl <= 1'b0;
			end
		end else if (ccr_accept) begin
			ccr_wrote <= 1'b1;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (dflt) begin
			array_wr <= 1'b0;
			array_addr <= 16'h0000;
			array_wdata <= 8'h00;
		end else begin
			array_wr <= wr_req && is_arr && wl && !protected_addr;
			if (wr_req && is_arr) begin
				array_addr <= h_addr;
				array_wdata <= h_wdata;
			end
		end
	end

	// ****************************************
	// Supply and alarm flags.
	// ****************************************
	logic [1:0] match_prev, match_rise;
	assign match_rise = alarm_match & ~match_prev;

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			loss_flag <= 1'b1;
			backup_flag <= 1'b0;
		end else begin
			backup_flag <= !vcc_sync && vbk_sync;
			if (total_loss) begin
				loss_flag <= 1'b1;
			end else if (ccr_accept && is_clock_reg) begin
				loss_flag <= 1'b0;
			end
		end
	end

	always_ff @(posedge sys_clk) begin
		if (dflt) begin
			al_flag <= 2'h0;
			al_snap <= 2'h0;
			match_prev <= 2'h0;
		end else begin
			match_prev <= alarm_match;
			if (new_req && is_status && h_op == OP_READ_BEGIN) begin
				al_snap <= al_flag;
			end else if (new_req && h_op != OP_READ_BEGIN) begin
				al_snap <= 2'h0;
			end
			if (new_req && is_status && h_op == OP_READ_END) begin
				al_flag <= (al_flag & ~al_snap) | match_rise;
			end else begin
				al_flag <= al_flag | match_rise;
			end
		end
	end

	// ****************************************
	// Control bits.
	// ****************************************
	always_ff @(posedge sys_clk) begin
		if (dflt) begin
			prot_reg <= RST_CTRL;
			irq_reg <= RST_CTRL;
		end else if (ccr_accept && h_addr == ADDR_PROTECT) begin
			prot_reg <= {h_wdata[7:3], 3'h0};
		end else if (ccr_accept && h_addr == ADDR_IRQCTL) begin
			irq_reg <= {h_wdata[7:3], 3'h0};
		end
	end

	// ****************************************
	// Timebase from the oscillator pin.
	// ****************************************
	logic [16:0] acc, acc_sum;
	logic half_tick, half_phase, tick_hund;
	assign acc_sum = acc + HALF_HUND_STEP;

	// Two hundred half-ticks per second spread evenly over the 32768 oscillator edges.
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			acc <= 17'h00000;
			half_tick <= 1'b0;
			half_phase <= 1'b0;
		end else begin
			half_tick <= 1'b0;
			if (osc_sync && !osc_prev) begin
				if (acc_sum >= OSC_WRAP) begin
					acc <= acc_sum - OSC_WRAP;
					half_tick <= 1'b1;
				end else begin
					acc <= acc_sum;
				end
			end
			if (half_tick) begin
				half_phase <= ~half_phase;
			end
		end
	end

	assign tick_hund = half_tick && half_phase;

	// ****************************************
	// Calendar counting chain.
	// ****************************************
	function automatic logic [8:0] bcd_inc(input logic [7:0] v, input logic [7:0] top,
		input logic [7:0] bottom);
		if (v >= top) begin
			bcd_inc = {1'b1, bottom};
		end else if (v[3:0] >= 4'h9) begin
			bcd_inc = {1'b0, v[7:4] + 4'h1, 4'h0};
		end else begin
			bcd_inc = {1'b0, v + 8'h01};
		end
	endfunction : bcd_inc

	function automatic logic [7:0] month_len(input logic [7:0] mo, input logic [7:0] yr);
		logic leap;
		leap = yr[4] ? (yr[3:0] == 4'h2 || yr[3:0] == 4'h6) :
			(yr[3:0] == 4'h0 || yr[3:0] == 4'h4 || yr[3:0] == 4'h8);
		unique case (mo)
			8'h02: month_len = leap ? 8'h29 : 8'h28;
			8'h04, 8'h06, 8'h09, 8'h11: month_len = 8'h30;
			default: month_len = 8'h31;
		endcase
	endfunction : month_len

	logic [8:0] n_hund, n_sec, n_min, n_date, n_month, n_year, h24;
	logic [7:0] next_hour;
	logic hour_carry;
	logic [2:0] next_wday;

	always_comb begin
		n_hund = bcd_inc(hund, 8'h99, 8'h00);
		n_sec = bcd_inc(sec, 8'h59, 8'h00);
		n_min = bcd_inc(min, 8'h59, 8'h00);
		n_date = bcd_inc(date, month_len(month, year), 8'h01);
		n_month = bcd_inc(month, 8'h12, 8'h01);
		n_year = bcd_inc(year, 8'h99, 8'h00);
		h24 = bcd_inc({2'h0, hour[5:0]}, 8'h23, 8'h00);
		next_hour = hour;
		hour_carry = 1'b0;
		if (hour[7]) begin
			next_hour = {2'h2, h24[5:0]};
			hour_carry = h24[8];
		end else if (hour[4:0] == 5'h11) begin
			next_hour = {2'h0, ~hour[5], 5'h12};
			hour_carry = hour[5];
		end else if (hour[4:0] >= 5'h12) begin
			next_hour = {2'h0, hour[5], 5'h01};
		end else begin
			next_hour = {2'h0, hour[5], 5'(hour[4:0] + 5'h01)};
			if (hour[3:0] == 4'h9) begin
				next_hour = {2'h0, hour[5], 5'h10};
			end
		end
		next_wday = (wday >= 3'h6) ? 3'h0 : 3'(wday + 3'h1);
	end

	always_ff @(posedge sys_clk) begin
		if (dflt) begin
			hund <= 8'h00;
			sec <= RST_SEC;
			min <= RST_MIN;
			hour <= RST_HOUR;
			date <= RST_DATE;
			month <= RST_MONTH;
			year <= RST_YEAR;
			wday <= 3'h0;
		end else if (ccr_accept && is_clock_reg) begin
			unique case (h_addr)
				ADDR_SEC: sec <= h_wdata & 8'h7F;
				ADDR_MIN: min <= h_wdata & 8'h7F;
				ADDR_HOUR: hour <= h_wdata & 8'hBF;
				ADDR_DATE: date <= h_wdata & 8'h3F;
				ADDR_MONTH: month <= h_wdata & 8'h1F;
				ADDR_YEAR: year <= h_wdata;
				ADDR_WDAY: wday <= h_wdata[2:0];
				default: hund <= hund;
			endcase
		end else if (tick_hund && !loss_flag) begin
			hund <= n_hund[7:0];
			if (n_hund[8]) begin
				sec <= n_sec[7:0];
				if (n_sec[8]) begin
					min <= n_min[7:0];
					if (n_min[8]) begin
						hour <= next_hour;
						if (hour_carry) begin
							date <= n_date[7:0];
							wday <= next_wday;
							if (n_date[8]) begin
								month <= n_month[7:0];
								if (n_month[8]) begin
									year <= n_year[7:0];
								end
							end
						end
					end
				end
			end
		end
	end

	// ****************************************
	// Watchdog period.
	// ****************************************
	logic [7:0] wd_count, wd_limit;

	always_comb begin
		unique case (prot_reg[4:3])
			2'h0: wd_limit = WD_LONG_TICKS;
			2'h1: wd_limit = WD_MID_TICKS;
			2'h2: wd_limit = WD_SHORT_TICKS;
			default: wd_limit = 8'h00;
		endcase
	end

	always_ff @(posedge sys_clk) begin
		if (dflt) begin
			wd_count <= 8'h00;
			wd_expire <= 1'b0;
		end else begin
			wd_expire <= 1'b0;
			if (wd_kick || wd_limit == 8'h00) begin
				wd_count <= 8'h00;
			end else if (tick_hund) begin
				if (wd_count >= wd_limit - 8'h01) begin
					wd_count <= 8'h00;
					wd_expire <= 1'b1;
				end else begin
					wd_count <= wd_count + 8'h01;
				end
			end
		end
	end

	// ****************************************
	// Interrupt pulse and frequency output.
	// ****************************************
	logic [PW-1:0] pulse_cnt;
	logic [1:0] fire;

	// Single mode fires only when the flag was clear; repeat mode fires on every match.
	assign fire = match_rise & {irq_reg[6], irq_reg[5]} & (irq_reg[7] ? 2'h3 : ~al_flag);

	always_ff @(posedge sys_clk) begin
		if (dflt) begin
			pulse_cnt <= '0;
		end else if (|fire) begin
			pulse_cnt <= PW'(PULSE_CYCLES);
		end else if (pulse_cnt != '0) begin
			pulse_cnt <= pulse_cnt - PW'(1);
		end
	end

	always_ff @(posedge sys_clk) begin
		if (dflt) begin
			irq_n <= 1'b1;
			frequency_out_pin <= 1'b0;
		end else begin
			irq_n <= !(irq_reg[4:3] == FO_IRQ && pulse_cnt != '0);
			unique case (irq_reg[4:3])
				FO_32K: frequency_out_pin <= osc_sync;
				FO_100HZ: frequency_out_pin <= half_phase;
				FO_1HZ: frequency_out_pin <= hund < 8'h50;
				default: frequency_out_pin <= 1'b0;
			endcase
		end
	end
endmodule : rcsc_core

// ===== include/rcsc_pkg.sv
// Shared constants and types of the real-time clock, calendar and status core.
package rcsc_pkg;
	typedef enum logic [1:0] {OP_WRITE, OP_READ_BEGIN, OP_READ_END, OP_STOP} rcsc_op_e;
	localparam logic [3:0] SPACE_CCR = 4'hD;
	localparam logic [3:0] SPACE_ARRAY = 4'hA;
	localparam logic [15:0] ADDR_PROTECT = 16'h0010;
	localparam logic [15:0] ADDR_IRQCTL = 16'h0011;
	localparam logic [15:0] ADDR_SEC = 16'h0030;
	localparam logic [15:0] ADDR_MIN = 16'h0031;
	localparam logic [15:0] ADDR_HOUR = 16'h0032;
	localparam logic [15:0] ADDR_DATE = 16'h0033;
	localparam logic [15:0] ADDR_MONTH = 16'h0034;
	localparam logic [15:0] ADDR_YEAR = 16'h0035;
	localparam logic [15:0] ADDR_WDAY = 16'h0036;
	localparam logic [15:0] ADDR_HUND = 16'h0037;
	localparam logic [15:0] ADDR_STATUS = 16'h003F;
	localparam int ST_BACKUP = 7;
	localparam int ST_AL1 = 6;
	localparam int ST_AL0 = 5;
	localparam int ST_RWL = 2;
	localparam int ST_WL = 1;
	localparam int ST_LOSS = 0;
	localparam logic [7:0] SR_SET_WL = 8'h02;
	localparam logic [7:0] SR_SET_RWL = 8'h06;
	localparam logic [7:0] SR_CLEAR = 8'h00;
	localparam logic [7:0] RST_SEC = 8'h00;
	localparam logic [7:0] RST_MIN = 8'h00;
	localparam logic [7:0] RST_HOUR = 8'h12;
	localparam logic [7:0] RST_DATE = 8'h01;
	localparam logic [7:0] RST_MONTH = 8'h01;
	localparam logic [7:0] RST_YEAR = 8'h00;
	localparam logic [7:0] RST_CTRL = 8'h00;
	localparam logic [15:0] PROT_QUARTER = 16'h6000;
	localparam logic [15:0] PROT_HALF = 16'h4000;
	localparam logic [15:0] PROT_PG1 = 16'h007F;
	localparam logic [15:0] PROT_PG2 = 16'h00FF;
	localparam logic [15:0] PROT_PG4 = 16'h01FF;
	localparam logic [15:0] PROT_PG8 = 16'h03FF;
	localparam logic [1:0] FO_IRQ = 2'h0;
	localparam logic [1:0] FO_32K = 2'h1;
	localparam logic [1:0] FO_100HZ = 2'h2;
	localparam logic [1:0] FO_1HZ = 2'h3;
	localparam int HUND_MS = 10;
	localparam int WD_LONG_MS = 1750;
	localparam int WD_MID_MS = 750;
	localparam int WD_SHORT_MS = 250;
	localparam logic [7:0] WD_LONG_TICKS = 8'(WD_LONG_MS / HUND_MS);
	localparam logic [7:0] WD_MID_TICKS = 8'(WD_MID_MS / HUND_MS);
	localparam logic [7:0] WD_SHORT_TICKS = 8'(WD_SHORT_MS / HUND_MS);
	localparam int SYS_CLK_HZ = 25000000;
	localparam int IRQ_PULSE_MS = 20;
	localparam int IRQ_PULSE_CYCLES = IRQ_PULSE_MS * (SYS_CLK_HZ / 1000);
	localparam logic [16:0] OSC_WRAP = 17'h08000;
	localparam logic [16:0] HALF_HUND_STEP = 17'h000C8;
endpackage : rcsc_pkg

// ===== testbench/rcsc_host.sv
// Host model that issues byte requests to the core over the link.
`timescale 1ns/1ps
module rcsc_host import rcsc_pkg::*; (
	input wire logic link_clk,
	input wire logic link_done,
	input wire logic link_ack,
	input wire logic [7:0] link_rdata,
	output logic link_req,
	output rcsc_op_e link_op,
	output logic [3:0] link_space,
	output logic [15:0] link_addr,
	output logic [7:0] link_wdata
);
	initial begin
		link_req = 1'b0;
		link_op = OP_STOP;
		link_space = 4'h0;
		link_addr = 16'h0000;
		link_wdata = 8'h00;
	end
	// One byte per request; stops are sent by the caller between transfers.
	task automatic xfer(input rcsc_op_e op, input logic [3:0] sp, input logic [15:0] ad,
		input logic [7:0] wd, output logic ack, output logic [7:0] rd);
		int n;
		n = 0;
		@(negedge link_clk);
		link_req = 1'b1;
		link_op = op;
		link_space = sp;
		link_addr = ad;
		link_wdata = wd;
		@(negedge link_clk);
		link_req = 1'b0;
		link_space = ~sp;
		link_addr = ~ad;
		link_wdata = ~wd;
		while (link_done !== 1'b1 && n < 40) begin
			@(negedge link_clk);
			n++;
		end
		ack = (link_done === 1'b1) ? link_ack : 1'bx;
		rd = (link_done === 1'b1) ? link_rdata : 8'hXX;
	endtask : xfer
endmodule : rcsc_host

// ===== testbench/rcsc_core_asserts.sv
// Port-level assertions for the real-time clock core.
`timescale 1ns/1ps
module rcsc_core_asserts #(
	parameter int PULSE_CYCLES = 20
) (
	input wire logic sys_clk,
	input wire logic rst,
	input wire logic link_clk,
	input wire logic link_req,
	input wire logic link_busy,
	input wire logic link_done,
	input wire logic link_ack,
	input wire logic [7:0] link_rdata,
	input wire logic [1:0] alarm_match,
	input wire logic wd_expire,
	input wire logic irq_n,
	input wire logic frequency_out_pin,
	input wire logic array_wr
);
	logic [31:0] low_cnt;
	logic [3:0] since_rise;
	logic [1:0] lk_age;
	// Link outputs settle two link edges after reset; compare only from then on.
	always_ff @(posedge link_clk) begin
		if (rst)
			lk_age <= 2'h0;
		else if (!lk_age[1])
			lk_age <= lk_age + 2'h1;
	end
	always_ff @(posedge sys_clk) begin
		if (rst || irq_n)
			low_cnt <= 32'h0;
		else
			low_cnt <= low_cnt + 32'h1;
	end
	always_ff @(posedge sys_clk) begin
		if (rst)
			since_rise <= 4'hF;
		else if ((alarm_match & ~$past(alarm_match)) != 2'h0)
			since_rise <= 4'h0;
		else if (since_rise != 4'hF)
			since_rise <= since_rise + 4'h1;
	end
	AST_IRQ_WIDTH: assert property (@(posedge sys_clk) disable iff (rst)
		$rose(irq_n) |-> low_cnt == 32'(PULSE_CYCLES)) else $error("irq pulse width");
	AST_IRQ_CAUSE: assert property (@(posedge sys_clk) disable iff (rst)
		$fell(irq_n) |-> since_rise < 4'h8) else $error("irq without match");
	AST_IRQ_NOT_FREQ: assert property (@(posedge sys_clk) disable iff (rst)
		!irq_n |-> !frequency_out_pin) else $error("irq with frequency output");
	AST_ARRAY_PULSE: assert property (@(posedge sys_clk) disable iff (rst)
		array_wr |=> !array_wr) else $error("array write too long");
	AST_ARRAY_IN_XFER: assert property (@(posedge sys_clk) disable iff (rst)
		array_wr |-> link_busy) else $error("array write outside request");
	AST_WD_PULSE: assert property (@(posedge sys_clk) disable iff (rst)
		wd_expire |=> !wd_expire) else $error("watchdog pulse too long");
	AST_BUSY_ANSWER: assert property (@(posedge link_clk) disable iff (rst)
		$rose(link_busy) |-> ##[1:16] link_done) else $error("no answer");
	AST_DONE_FREES: assert property (@(posedge link_clk) disable iff (rst)
		link_done |-> !link_busy) else $error("busy with done");
	AST_REQ_TAKEN: assert property (@(posedge link_clk) disable iff (rst)
		link_req && !link_busy |=> link_busy) else $error("request not taken");
	AST_ANSWER_STANDS: assert property (@(posedge link_clk) disable iff (rst)
		lk_age[1] && !link_done |-> $stable(link_rdata) && $stable(link_ack))
		else $error("answer moved");
	COV_IRQ: cover property (@(posedge sys_clk) $fell(irq_n));
	COV_ARRAY: cover property (@(posedge sys_clk) array_wr);
	COV_NACK: cover property (@(posedge link_clk) link_done && !link_ack);
endmodule : rcsc_core_asserts
bind rcsc_core rcsc_core_asserts #(.PULSE_CYCLES(PULSE_CYCLES)) u_chk (.sys_clk(sys_clk),
	.rst(rst), .link_clk(link_clk), .link_req(link_req), .link_busy(link_busy),
	.link_done(link_done), .link_ack(link_ack), .link_rdata(link_rdata),
	.alarm_match(alarm_match), .wd_expire(wd_expire), .irq_n(irq_n),
	.frequency_out_pin(frequency_out_pin), .array_wr(array_wr));

// ===== testbench/rcsc_core_test.sv
// Self-checking bench for the real-time clock core.
`timescale 1ns/1ps
module rcsc_core_test import rcsc_pkg::*; ;
	localparam int PW = 20;
	logic sys_clk, link_clk, rst, osc_in, vcc_good, vback_good, wd_kick, ack;
	logic link_req, link_busy, link_done, link_ack, wd_expire, irq_n, frequency_out_pin, array_wr;
	logic [1:0] alarm_match;
	rcsc_op_e link_op;
	logic [3:0] link_space;
	logic [15:0] link_addr, array_addr;
	logic [7:0] link_wdata, link_rdata, array_wdata, rd, val;
	int err_total, checks_done, arr_cnt, lows, highs;
	rcsc_core #(.PULSE_CYCLES(PW)) i_dut (.*);
	rcsc_host i_host (.*);
	initial begin
		sys_clk = 1'b0;
		forever #20 sys_clk = ~sys_clk;
	end
	initial begin
		link_clk = 1'b0;
		#3;
		forever #32 link_clk = ~link_clk;
	end
	always #80 osc_in = ~osc_in;
	always @(posedge sys_clk)
		if (array_wr === 1'b1)
			arr_cnt <= arr_cnt + 1;
	task automatic cmp(input logic [7:0] got, input logic [7:0] exp);
		checks_done++;
		if (got !== exp) begin
			err_total++;
			$display("ERROR %0t got %h expected %h", $time, got, exp);
		end
	endtask : cmp
	task automatic acc(input rcsc_op_e op, input logic [3:0] sp, input logic [15:0] ad,
		input logic [7:0] wd);
		i_host.xfer(op, sp, ad, wd, ack, rd);
	endtask : acc
	task automatic xstop();
		acc(OP_STOP, SPACE_CCR, 16'h0000, 8'h00);
	endtask : xstop
	task automatic wrck(input logic [3:0] sp, input logic [15:0] ad, input logic [7:0] wd,
		input logic ea);
		acc(OP_WRITE, sp, ad, wd);
		cmp({7'h00, ack}, {7'h00, ea});
	endtask : wrck
	task automatic rdv(input logic [15:0] ad);
		acc(OP_READ_BEGIN, SPACE_CCR, ad, 8'h00);
		val = rd;
		acc(OP_READ_END, SPACE_CCR, ad, 8'h00);
		xstop();
	endtask : rdv
	task automatic rdck(input logic [15:0] ad, input logic [7:0] exp);
		rdv(ad);
		cmp(val, exp);
	endtask : rdck
	task automatic ctl(input logic [15:0] ad, input logic [7:0] v);
		wrck(SPACE_CCR, ADDR_STATUS, SR_SET_WL, 1'b1);
		xstop();
		wrck(SPACE_CCR, ADDR_STATUS, SR_SET_RWL, 1'b1);
		xstop();
		wrck(SPACE_CCR, ad, v, 1'b1);
		xstop();
	endtask : ctl
	task automatic pulse(input int i, input logic [7:0] exp);
		lows = 0;
		highs = 0;
		@(negedge sys_clk);
		alarm_match[i] = 1'b1;
		repeat (40) begin
			@(negedge sys_clk);
			alarm_match[i] = 1'b0;
			lows += (irq_n === 1'b0);
			highs += (frequency_out_pin === 1'b1);
		end
		cmp(8'(lows), exp);
	endtask : pulse
	task automatic sup(input logic vc, input logic vb);
		@(negedge sys_clk);
		vcc_good = vc;
		vback_good = vb;
		repeat (10) @(negedge sys_clk);
	endtask : sup
	task automatic t_reset();
		rdck(ADDR_STATUS, 8'h01);
		rdck(ADDR_HOUR, RST_HOUR);
		rdck(ADDR_WDAY, 8'h00);
		rdck(16'h0020, 8'h00);
		repeat (4000) @(negedge sys_clk);
		rdck(ADDR_HUND, 8'h00);
	endtask : t_reset
	task automatic t_locked();
		wrck(SPACE_CCR, ADDR_SEC, 8'h45, 1'b0);
		wrck(SPACE_ARRAY, 16'h0100, 8'h3C, 1'b0);
		xstop();
		rdck(ADDR_SEC, 8'h00);
		cmp(8'(arr_cnt), 8'h00);
		wrck(4'h5, ADDR_STATUS, SR_SET_WL, 1'b0);
		xstop();
		rdck(ADDR_STATUS, 8'h01);
	endtask : t_locked
	task automatic t_unlock();
		wrck(SPACE_CCR, ADDR_STATUS, SR_SET_WL, 1'b1);
		xstop();
		rdck(ADDR_STATUS, 8'h03);
		wrck(SPACE_CCR, ADDR_STATUS, SR_SET_RWL, 1'b1);
		xstop();
		rdck(ADDR_STATUS, 8'h07);
		wrck(SPACE_CCR, ADDR_HUND, 8'h55, 1'b1);
		wrck(SPACE_CCR, ADDR_SEC, 8'h58, 1'b1);
		xstop();
		rdck(ADDR_STATUS, SR_SET_WL);
		rdck(ADDR_SEC, 8'h58);
		rdv(ADDR_HUND);
		cmp(8'(val < 8'h02), 8'h01);
		repeat (4000) @(negedge sys_clk);
		rdv(ADDR_HUND);
		cmp(8'(val > 8'h01 && val[3:0] < 4'hA), 8'h01);
	endtask : t_unlock
	task automatic t_alarm();
		ctl(ADDR_IRQCTL, 8'h60);
		pulse(0, 8'(PW));
		acc(OP_READ_BEGIN, SPACE_CCR, ADDR_STATUS, 8'h00);
		cmp(rd, 8'h22);
		pulse(1, 8'(PW));
		acc(OP_READ_END, SPACE_CCR, ADDR_STATUS, 8'h00);
		xstop();
		rdck(ADDR_STATUS, 8'h42);
		pulse(1, 8'(PW));
		pulse(1, 8'h00);
		pulse(0, 8'(PW));
		ctl(ADDR_IRQCTL, 8'h40);
		rdck(ADDR_STATUS, 8'h62);
		pulse(0, 8'h00);
		rdck(ADDR_STATUS, 8'h22);
		ctl(ADDR_IRQCTL, 8'hC0);
		pulse(1, 8'(PW));
		pulse(1, 8'(PW));
	endtask : t_alarm
	task automatic t_outsel();
		for (int f = 1; f < 4; f++) begin
			ctl(ADDR_IRQCTL, 8'h60 | 8'(f << 3));
			pulse(0, 8'h00);
			if (f == 1)
				cmp(8'(highs > 0), 8'h01);
		end
		rdck(ADDR_STATUS, 8'h62);
	endtask : t_outsel
	task automatic t_array();
		ctl(ADDR_PROTECT, 8'h20);
		wrck(SPACE_ARRAY, PROT_QUARTER, 8'h11, 1'b1);
		wrck(SPACE_ARRAY, 16'h5FFF, 8'hA5, 1'b1);
		xstop();
		cmp(8'(arr_cnt), 8'h01);
		cmp(array_wdata, 8'hA5);
		cmp(array_addr[15:8], 8'h5F);
		wrck(SPACE_CCR, ADDR_STATUS, SR_CLEAR, 1'b1);
		xstop();
		wrck(SPACE_ARRAY, 16'h0000, 8'h77, 1'b0);
		xstop();
		rdck(ADDR_STATUS, 8'h00);
	endtask : t_array
	task automatic t_supply();
		sup(1'b0, 1'b1);
		rdck(ADDR_STATUS, 8'h80);
		sup(1'b1, 1'b1);
		rdck(ADDR_STATUS, 8'h00);
		sup(1'b0, 1'b0);
		sup(1'b1, 1'b1);
		rdck(ADDR_STATUS, 8'h01);
	endtask : t_supply
	task automatic t_wdog();
		int n;
		n = 0;
		ctl(ADDR_PROTECT, 8'h10);
		@(negedge sys_clk);
		wd_kick = 1'b1;
		@(negedge sys_clk);
		wd_kick = 1'b0;
		while (wd_expire !== 1'b1 && n < 34000) begin
			@(negedge sys_clk);
			n++;
		end
		cmp(8'(n > 31400 && n < 32830), 8'h01);
	endtask : t_wdog
	task automatic summarize();
		if (err_total == 0 && checks_done > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask : summarize
	initial begin
		rst = 1'b1;
		osc_in = 1'b0;
		vcc_good = 1'b1;
		vback_good = 1'b1;
		alarm_match = 2'h0;
		wd_kick = 1'b0;
		err_total = 0;
		checks_done = 0;
		arr_cnt = 0;
		repeat (4) @(posedge sys_clk);
		@(negedge sys_clk);
		rst = 1'b0;
		repeat (10) @(posedge link_clk);
		t_reset();
		t_locked();
		t_unlock();
		t_alarm();
		t_outsel();
		t_array();
		t_supply();
		t_wdog();
		summarize();
	end
	initial begin
		#3000000;
		err_total++;
		summarize();
	end
endmodule : rcsc_core_test
